// >>> pbd_decoder.sv
// Purpose: Classify PCI master memory cycles into BIOS decode and main memory select.
// Assumes: Address phase marked by frameStart with address and command valid in that cycle.
// Notes: BIOS decode results are registered and held until the next address phase; the main memory select lasts one clock.
// Operation
// R1: Top 128 KB of first megabyte is BIOS; aliases at 4 GB and 4 GB-1 MB.
// R2: BIOS split in 64 KB halves; upper always on, lower switchable with aliases.
// R3: Enabled lower half is positively decoded and gives encoded BIOS chip select.
// R4: Upper half positive only when clock divisor bit 6 set, else subtractive.
// R5: Global memory select enable forces both halves and aliases subtractive.
// R6: Forwarded alias at 4 GB minus 1 MB drives ISA LA20 high.
// R7: Enabled 384 KB enlarged region is positive, forwarded and chip selected.
// R8: Forwarded enlarged access drives ISA LA23 to LA20 all ones.
// R9: Every positively decoded enabled BIOS cycle is passed to ISA.
// R10: Burst reads from BIOS end with disconnect after first data phase.
// R11: Upper half and aliases always give chip select; enable picks decode.
// R12: Lower half disabled: subtractive without select; high aliases unclaimed.
// R13: Enlarged region disabled: no decode of any kind, no chip select.
// R14: Software must keep ISA memory off the aliased BIOS areas.
// R15: Sixteen select ranges; fourteen read/write enabled, two single enable.
// R16: Sixteenth range starts at 1 MB, top in 2 MB steps to 512 MB; the code's top is 1 MB plus the steps, at most 511 MB.
// R17: Address in any enabled range asserts main memory select.
// R18: Addresses inside the programmable hole never assert main memory select.
// R19: Main memory select active one clock, from edge after frame start.
// R20: Global enable also enables 0 to 512 KB for reads and writes.
// R21: Decode uses address and command latched in memory address phases only.
module pbd_decoder
  import pbd_pkg::*;
#(
  parameter int RW_RANGES = NUM_RW_RANGES
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      frameStart,
  input  wire logic [31:0]               pciAddress,
  input  wire logic [3:0]                pciCommand,
  input  wire logic                      dataPhaseDone,
  input  wire logic [7:0]                isaClockDivisor,
  input  wire logic [7:0]                mainMemorySelectControl,
  input  wire logic [7:0]                utility_chip_select_enable_a,
  input  wire pbd_range_type [RW_RANGES-1:0] rwRange,
  input  wire logic [RW_RANGES-1:0]      rangeReadEnable,
  input  wire logic [RW_RANGES-1:0]      rangeWriteEnable,
  input  wire logic                      highRangeEnable,
  input  wire logic [7:0]                highRangeTopSteps,
  input  wire logic                      holeEnable,
  input  wire logic [31:0]               holeBase,
  input  wire logic [31:0]               holeLast,
  output logic                           biosPositive,
  output logic                           biosSubtractive,
  output logic                           encoded_bios_chip_select_n,
  output logic                           isaLa20High,
  output logic                           isaLaTopOnes,
  output logic                           targetDisconnect,
  output logic                           main_memory_select_n
);

  // Memory commands are the only ones the decoder looks at.
  // Configuration and I/O cycles share the address lines, so an I/O address
  // that happens to match a BIOS bound must never be claimed here.
  // The command set is a fixed list, which keeps the compare small.
  function automatic logic is_memory(input logic [3:0] cmd);
    is_memory = (cmd == CMD_MEM_READ) || (cmd == CMD_MEM_WRITE) ||
                (cmd == CMD_MEM_RD_MULT) || (cmd == CMD_MEM_RD_LINE) ||
                (cmd == CMD_MEM_WR_INV);
  endfunction

  function automatic logic is_read(input logic [3:0] cmd);
    is_read = (cmd == CMD_MEM_READ) || (cmd == CMD_MEM_RD_MULT) ||
              (cmd == CMD_MEM_RD_LINE);
  endfunction

  // Match a 128 KB aligned region.
  function automatic logic in_region(input logic [31:0] a, input logic [31:0] base);
    in_region = (a[31:REGION_SHIFT] == base[31:REGION_SHIFT]);
  endfunction

  typedef struct packed {
    pbd_bios_type bios;
    logic         memSelect;
    logic         burstRead;
  } pbd_state_type;

  pbd_state_type state;
  pbd_state_type next_state;

  logic              memCycle;
  logic              readCycle;
  logic              inFirstMeg;
  logic              in4g;
  logic              in4gm1;
  logic              inEnlarged;
  logic              upperHalf;
  logic              topPosEn;
  logic              lowEn;
  logic              enlEn;
  logic              globalEn;
  logic [RW_RANGES-1:0] rangeHit;
  logic              lowHit;
  logic              highHit;
  logic              holeHit;
  logic [31:0]       highTop;
  pbd_bios_type      bios;

  // Address classification is done on the address phase values only.
  assign memCycle   = frameStart && is_memory(pciCommand); // R21
  assign readCycle  = is_read(pciCommand);
  assign inFirstMeg = in_region(pciAddress, BIOS_LOW_BASE); // R1
  assign in4g       = in_region(pciAddress, ALIAS4G_BASE); // R1
  assign in4gm1     = in_region(pciAddress, ALIAS4GM1_BASE); // R1
  assign inEnlarged = (pciAddress >= ENL_BASE) && (pciAddress <= ENL_LAST); // R7
  assign upperHalf  = pciAddress[UPPER_HALF_BIT]; // R2
  assign globalEn   = mainMemorySelectControl[MCSCTL_GLOBAL_BIT];
  assign topPosEn   = isaClockDivisor[CLKDIV_TOPEN_BIT] && !globalEn; // R4 R5
  assign lowEn      = utility_chip_select_enable_a[UCSA_LOWEN_BIT]; // R12
  assign enlEn      = utility_chip_select_enable_a[UCSA_ENLEN_BIT]; // R13

  // BIOS decode table: the alias regions differ only in LA20 handling and claiming.
  // The upper half is always claimed somehow, so it always gets a chip select.
  // The lower half follows its enable in all three places at once.
  // A disabled lower half is still forwarded in the first megabyte, but its
  // high aliases are left alone so another agent may answer there.
  // The global select enable only changes positive into subtractive decode;
  // it never removes a claim, which keeps the reset vector reachable.
  // The enlarged region is reachable only from the high aliases' neighbourhood.
  always_comb begin
    bios = '0;
    if (inFirstMeg || in4g || in4gm1) begin
      if (upperHalf) begin
        bios.chipSelect  = 1'b1; // R11
        bios.positive    = topPosEn; // R4 R11
        bios.subtractive = !topPosEn; // R5
      end else if (lowEn) begin
        bios.chipSelect  = 1'b1; // R3
        bios.positive    = !globalEn; // R3 R5
        bios.subtractive = globalEn; // R5
      end else begin
        bios.subtractive = inFirstMeg; // R12
      end
      bios.forceLa20 = in4gm1 && (bios.positive || bios.subtractive); // R6
    end else if (inEnlarged && enlEn) begin
      bios.chipSelect = 1'b1; // R7
      bios.positive   = 1'b1; // R7 R9
      bios.forceLaTop = 1'b1; // R8
    end
    bios.burstStop = bios.positive || bios.subtractive;
  end

  // Main memory select range matching; the hole overrides every range.
  // Each range compares the full address, which costs comparators but lets the
  // range table hold any granularity without extra mask logic.
  // Reads and writes pick their own enable, so a range can shadow one direction.
  // Limitation: overlapping ranges simply OR together.
  genvar gi;
  generate
    for (gi = 0; gi < RW_RANGES; gi++) begin : g_range
      assign rangeHit[gi] = (pciAddress >= rwRange[gi].base) &&
                            (pciAddress <= rwRange[gi].last) &&
                            (readCycle ? rangeReadEnable[gi] : rangeWriteEnable[gi]); // R15
    end
  endgenerate

  // Top is 1 MB plus the programmed number of 2 MB steps, not capped; 255 steps give 511 MB.
  assign highTop = MB1 + STEP_2MB * 32'(highRangeTopSteps); // R16
  assign lowHit  = globalEn && (pciAddress < KB512); // R20
  assign highHit = highRangeEnable && (pciAddress >= MB1) && (pciAddress < highTop); // R16
  assign holeHit = holeEnable && (pciAddress >= holeBase) && (pciAddress <= holeLast); // R18

  // One state update per clock; select lasts one clock, BIOS answer held per cycle.
  // The select bit is cleared every clock so it can never stretch past one cycle.
  // A non-memory address phase clears the BIOS answer so a stale claim from the
  // previous cycle cannot leak into an I/O or configuration cycle.
  // Back to back memory frames simply overwrite the held answer.
  always_comb begin
    next_state = state;
    next_state.memSelect = 1'b0; // R19
    if (memCycle) begin
      next_state.bios      = bios; // R21
      next_state.burstRead = readCycle;
      next_state.memSelect = globalEn && !holeHit && (lowHit || highHit || |rangeHit); // R17 R18
    end else if (frameStart) begin
      next_state.bios = '0; // R21
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs come straight from the state flip-flops.
  // Only the disconnect is combinational, because it must answer in the very
  // data phase that completes; registering it would let a second phase slip in.
  // Active-low outputs are inverted here so the state stays active high.
  assign biosPositive               = state.bios.positive; // R9
  assign biosSubtractive            = state.bios.subtractive;
  assign encoded_bios_chip_select_n = !state.bios.chipSelect;
  assign isaLa20High                = state.bios.forceLa20; // R6
  assign isaLaTopOnes               = state.bios.forceLaTop; // R8
  assign targetDisconnect           = state.bios.burstStop && state.burstRead && dataPhaseDone; // R10
  assign main_memory_select_n       = !state.memSelect; // R19

  a_select_one_clock : assert property (@(posedge clk) disable iff (!rst_n)
    !main_memory_select_n |=> !main_memory_select_n == 1'b0 || $past(memCycle)) // R19
    else $error("Main memory select held longer than one clock.");

  a_select_after_frame : assert property (@(posedge clk) disable iff (!rst_n)
    !main_memory_select_n |-> $past(memCycle)) // R19
    else $error("Main memory select without a memory address phase.");

  a_hole_blocks : assert property (@(posedge clk) disable iff (!rst_n)
    (memCycle && holeHit) |=> main_memory_select_n) // R18
    else $error("Main memory select asserted inside the hole.");

  a_low_range_auto : assert property (@(posedge clk) disable iff (!rst_n)
    (memCycle && globalEn && !holeHit && pciAddress < KB512) |=> !main_memory_select_n) // R20
    else $error("Low 512 KB not selected under global enable.");

  a_global_no_pos : assert property (@(posedge clk) disable iff (!rst_n)
    (memCycle && globalEn && !inEnlarged) |=> !biosPositive) // R5
    else $error("BIOS halves positively decoded under global enable.");

  a_enl_disabled : assert property (@(posedge clk) disable iff (!rst_n)
    (memCycle && inEnlarged && !enlEn) |=> (!biosPositive && !biosSubtractive &&
      encoded_bios_chip_select_n)) // R13
    else $error("Disabled enlarged region was claimed.");

  a_alias_la20 : assert property (@(posedge clk) disable iff (!rst_n)
    (memCycle && in4gm1 && upperHalf) |=> isaLa20High) // R6
    else $error("LA20 not forced for the 4 GB-1 MB alias.");

  a_upper_cs : assert property (@(posedge clk) disable iff (!rst_n)
    (memCycle && upperHalf && (inFirstMeg || in4g || in4gm1)) |=>
      (!encoded_bios_chip_select_n && (biosPositive != biosSubtractive))) // R11
    else $error("Upper half lacks chip select or a single decode kind.");

  a_low_alias_off : assert property (@(posedge clk) disable iff (!rst_n)
    (memCycle && !upperHalf && !lowEn && (in4g || in4gm1)) |=>
      (!biosPositive && !biosSubtractive)) // R12
    else $error("Disabled lower half alias was claimed.");

  a_enl_top_ones : assert property (@(posedge clk) disable iff (!rst_n)
    (memCycle && inEnlarged && enlEn) |=> (isaLaTopOnes && biosPositive)) // R7 R8
    else $error("Enlarged access not positively forwarded with top lines high.");

  // The checks below look at the registered answer one clock after each
  // address phase, except a_pos_has_cs, a_decode_exclusive and a_la_top_claimed,
  // which check it on every clock. They use the same classification terms as the
  // logic, so they guard the table and the timing rather than the address compares.
  // Every one of them is disabled while reset is held, since the state is
  // forced to zero then and no address phase is taken.
  // A failing check names the rule that it guards in the label's comment.

  // An enabled lower half in the first megabyte is claimed with chip select.
  a_low_pos_cs : assert property (@(posedge clk) disable iff (!rst_n) // R3
    (memCycle && inFirstMeg && !upperHalf && lowEn && !globalEn) |=>
      (biosPositive && !encoded_bios_chip_select_n))
    else $error("Enabled lower half not positively decoded.");

  // The upper half follows its enable bit when the global enable is clear.
  a_top_pos_bit : assert property (@(posedge clk) disable iff (!rst_n) // R4
    (memCycle && inFirstMeg && upperHalf && isaClockDivisor[CLKDIV_TOPEN_BIT] &&
      !globalEn) |=> biosPositive)
    else $error("Upper half not positive with its enable set.");

  // With its enable clear the upper half is forwarded subtractively.
  a_top_sub_bit : assert property (@(posedge clk) disable iff (!rst_n) // R4
    (memCycle && inFirstMeg && upperHalf && !isaClockDivisor[CLKDIV_TOPEN_BIT]) |=>
      biosSubtractive)
    else $error("Upper half not subtractive with its enable clear.");

  // A disabled lower half is subtractive in the first megabyte, without select.
  a_low_first_sub : assert property (@(posedge clk) disable iff (!rst_n) // R12
    (memCycle && inFirstMeg && !upperHalf && !lowEn) |=>
      (biosSubtractive && encoded_bios_chip_select_n))
    else $error("Disabled lower half not subtractive without select.");

  // Every positive BIOS claim carries the chip select to the ISA side.
  a_pos_has_cs : assert property (@(posedge clk) disable iff (!rst_n) // R9
    biosPositive |-> !encoded_bios_chip_select_n)
    else $error("Positive BIOS decode without chip select.");

  // A cycle is never claimed both ways at once.
  a_decode_exclusive : assert property (@(posedge clk) disable iff (!rst_n) // R2
    !(biosPositive && biosSubtractive))
    else $error("Positive and subtractive decode together.");

  // Non-memory address phases leave every decode output idle.
  a_non_memory_idle : assert property (@(posedge clk) disable iff (!rst_n) // R21
    (frameStart && !memCycle) |=> (!biosPositive && !biosSubtractive &&
      encoded_bios_chip_select_n && main_memory_select_n))
    else $error("Non-memory cycle was decoded.");

  // The top address lines are forced only for a positive enlarged claim.
  a_la_top_claimed : assert property (@(posedge clk) disable iff (!rst_n) // R8
    isaLaTopOnes |-> biosPositive)
    else $error("Top address lines forced without a claim.");

  // LA20 is forced only for the alias below the top of 4 GB.
  a_la20_alias_only : assert property (@(posedge clk) disable iff (!rst_n) // R6
    (memCycle && !in4gm1) |=> !isaLa20High)
    else $error("LA20 forced outside the 4 GB-1 MB alias.");

  // The programmable high range selects main memory outside the hole.
  a_high_range_hit : assert property (@(posedge clk) disable iff (!rst_n) // R16
    (memCycle && globalEn && !holeHit && highHit) |=> !main_memory_select_n)
    else $error("High range address not selected.");

  // Any enabled table range selects main memory outside the hole.
  a_table_range_hit : assert property (@(posedge clk) disable iff (!rst_n) // R15
    (memCycle && globalEn && !holeHit && (|rangeHit)) |=> !main_memory_select_n)
    else $error("Enabled table range not selected.");

  // Without the global enable main memory is never selected.
  a_global_off : assert property (@(posedge clk) disable iff (!rst_n) // R17
    (memCycle && !globalEn) |=> main_memory_select_n)
    else $error("Main memory selected with global enable clear.");

endmodule // pbd_decoder

// >>> pbd_pkg.sv
// Purpose: Shared constants and carrier types for the PCI BIOS space and main memory select decoder.
// Assumes: 32-bit PCI addresses, memory read and write commands only.
// Notes: Region bounds are byte addresses; masks compare the upper address bits.
package pbd_pkg;
  localparam logic [31:0] BIOS_LOW_BASE    = 32'h000e0000; // Lower 64 KB half, first megabyte.
  localparam logic [31:0] BIOS_TOP_BASE    = 32'h000f0000; // Upper 64 KB half, first megabyte.
  localparam logic [31:0] ALIAS4G_BASE     = 32'hfffe0000; // Alias at the top of 4 GB.
  localparam logic [31:0] ALIAS4GM1_BASE   = 32'hffee0000; // Alias at 4 GB minus 1 MB.
  localparam logic [31:0] ENL_BASE         = 32'hfff80000; // Enlarged region start.
  localparam logic [31:0] ENL_LAST         = 32'hfffdffff; // Enlarged region end.
  localparam int          HALF_SHIFT       = 16;           // 64 KB granularity.
  localparam int          REGION_SHIFT     = 17;           // 128 KB granularity.
  localparam int          UPPER_HALF_BIT   = 16;           // Selects the upper 64 KB half.
  localparam int          CLKDIV_TOPEN_BIT = 6;            // Upper half positive decode enable.
  localparam int          MCSCTL_GLOBAL_BIT = 4;           // Global main memory select enable.
  localparam int          UCSA_LOWEN_BIT   = 6;            // Lower half enable.
  localparam int          UCSA_ENLEN_BIT   = 7;            // Enlarged region enable.
  localparam int          NUM_RW_RANGES    = 14;           // Ranges with read and write enables.
  localparam logic [31:0] MB1              = 32'h00100000;
  localparam logic [31:0] KB512            = 32'h00080000;
  localparam logic [31:0] STEP_2MB         = 32'h00200000;
  localparam logic [7:0]  TOP_MAX_STEPS    = 8'h00 + 8'd255; // 255 steps reach 510 MB plus base.
  localparam logic [3:0]  CMD_MEM_READ     = 4'h6;
  localparam logic [3:0]  CMD_MEM_WRITE    = 4'h7;
  localparam logic [3:0]  CMD_MEM_RD_MULT  = 4'hc;
  localparam logic [3:0]  CMD_MEM_RD_LINE  = 4'he;
  localparam logic [3:0]  CMD_MEM_WR_INV   = 4'hf;

  // One read/write range of the main memory select map.
  typedef struct packed {
    logic [31:0] base;
    logic [31:0] last;
  } pbd_range_type;

  // Decode answer for one PCI address phase.
  typedef struct packed {
    logic       positive;
    logic       subtractive;
    logic       chipSelect;
    logic       forceLa20;
    logic       forceLaTop;
    logic       burstStop;
  } pbd_bios_type;
endpackage : pbd_pkg

// >>> pbd_pci_master.sv
// Purpose: PCI master model that issues address phases and data phase completions.
// Assumes: The decoder samples its inputs on the rising edge of clk.
// Notes: Address and command are scrambled outside the address phase so stale values show up.
module pbd_pci_master (
  input  wire logic        clk,
  output logic             frameStart,
  output logic [31:0]      pciAddress,
  output logic [3:0]       pciCommand,
  output logic             dataPhaseDone
);
  timeunit 1ns;
  timeprecision 1ns;

  // The bus idles with no frame and no completed data phase.
  initial begin
    frameStart    = 1'b0;
    pciAddress    = 32'h00000000;
    pciCommand    = 4'h0;
    dataPhaseDone = 1'b0;
  end

  // One address phase; afterwards the lines carry the inverse, not a held copy.
  task automatic addressPhase(input logic [31:0] addr, input logic [3:0] cmd);
    @(negedge clk);
    frameStart = 1'b1;
    pciAddress = addr;
    pciCommand = cmd;
    @(negedge clk);
    frameStart = 1'b0;
    pciAddress = ~addr; // The decoder must have latched the address already.
    pciCommand = ~cmd;
  endtask

  // Marks a completed data phase from the next falling edge on.
  task automatic setDone(input logic value);
    @(negedge clk);
    dataPhaseDone = value;
  endtask
endmodule : pbd_pci_master

// >>> pbd_decoder_test.sv
// Purpose: Self-checking bench for the BIOS space and main memory select decoder.
// Assumes: Outputs settle within one clock of the address phase.
// Notes: Range table holds one read-only and one write-only range besides the fixed ones.
module pbd_decoder_test
  import pbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 clk;
  logic                 rst_n;
  logic [7:0]           isaClockDivisor;
  logic [7:0]           mainMemorySelectControl;
  logic [7:0]           utility_chip_select_enable_a;
  pbd_range_type [13:0] rwRange;
  logic [13:0]          rangeReadEnable;
  logic [13:0]          rangeWriteEnable;
  logic                 frameStart, dataPhaseDone;
  logic [31:0]          pciAddress;
  logic [3:0]           pciCommand;
  logic                 biosPositive, biosSubtractive, isaLa20High, isaLaTopOnes;
  logic                 encoded_bios_chip_select_n, targetDisconnect, main_memory_select_n;
  logic [45:0]          rows [26];
  logic [31:0]          addr;
  logic [3:0]           cmd, cfg;
  logic [5:0]           expected;
  logic                 highRangeEnable, holeEnable;
  int                   failures, compares;

  pbd_pci_master master (.clk(clk), .frameStart(frameStart), .pciAddress(pciAddress),
    .pciCommand(pciCommand), .dataPhaseDone(dataPhaseDone));

  pbd_decoder DUT (.clk(clk), .rst_n(rst_n), .frameStart(frameStart),
    .pciAddress(pciAddress), .pciCommand(pciCommand), .dataPhaseDone(dataPhaseDone),
    .isaClockDivisor(isaClockDivisor), .mainMemorySelectControl(mainMemorySelectControl),
    .utility_chip_select_enable_a(utility_chip_select_enable_a), .rwRange(rwRange),
    .rangeReadEnable(rangeReadEnable), .rangeWriteEnable(rangeWriteEnable),
    .highRangeEnable(highRangeEnable), .highRangeTopSteps(8'h02), .holeEnable(holeEnable),
    .holeBase(32'h00200000), .holeLast(32'h0020ffff), .biosPositive(biosPositive),
    .biosSubtractive(biosSubtractive), .encoded_bios_chip_select_n(encoded_bios_chip_select_n),
    .isaLa20High(isaLa20High), .isaLaTopOnes(isaLaTopOnes),
    .targetDisconnect(targetDisconnect), .main_memory_select_n(main_memory_select_n));

  // Clock at 100 MHz.
  always #5 clk = ~clk;

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  // Ends the run with the verdict.
  task automatic results();
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Unused bits are set so that a decoder reading the wrong bit is caught.
  task automatic setConfig(input logic [3:0] c);
    @(negedge clk);
    mainMemorySelectControl      = {3'h7, c[3], 4'hf};
    isaClockDivisor              = {1'b1, c[2], 6'h3f};
    utility_chip_select_enable_a = {c[0], c[1], 6'h3f};
  endtask

  // Guards against a hang anywhere in the sequence.
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    results();
  end

  // Rows: address, command, {global, upper, lower, enlarged}, expected
  // {positive, subtractive, chip select_n, LA20, LA top, memory select_n}.
  initial begin
    rows = '{
      {32'h000f0000, 4'h6, 4'h4, 6'h21}, {32'h000fffff, 4'h6, 4'h0, 6'h11},
      {32'h000e0000, 4'h7, 4'h2, 6'h21}, {32'h000effff, 4'h6, 4'h0, 6'h19},
      {32'hffff0000, 4'h6, 4'h4, 6'h21}, {32'hffef0000, 4'hc, 4'h0, 6'h15},
      {32'hffee0000, 4'h6, 4'h0, 6'h09}, {32'hffee0000, 4'he, 4'h2, 6'h25},
      {32'hfffe0000, 4'h6, 4'h0, 6'h09}, {32'hfff80000, 4'h6, 4'h1, 6'h23},
      {32'hfffdffff, 4'hf, 4'h1, 6'h23}, {32'hfff80000, 4'h6, 4'h0, 6'h09},
      {32'h000f0000, 4'h6, 4'hf, 6'h11}, {32'h000e0000, 4'h6, 4'ha, 6'h11},
      {32'h000f0000, 4'h2, 4'h4, 6'h09}, {32'h0007fffc, 4'h7, 4'h8, 6'h08},
      {32'h00000000, 4'h7, 4'h0, 6'h09}, {32'h00080000, 4'h6, 4'h8, 6'h09},
      {32'h000c0000, 4'h6, 4'h8, 6'h08}, {32'h000c0000, 4'h7, 4'h8, 6'h09},
      {32'h000d0000, 4'h7, 4'h8, 6'h08}, {32'h000d0000, 4'h6, 4'h8, 6'h09},
      {32'h004ffffc, 4'h6, 4'h8, 6'h08}, {32'h00500000, 4'h6, 4'h8, 6'h09},
      {32'h00200000, 4'h6, 4'h8, 6'h09}, {32'h00000000, 4'h2, 4'h8, 6'h09}};
    failures = 0;
    compares = 0;
    clk = 1'b0;
    rst_n = 1'b0;
    rwRange = '0;
    rwRange[0] = {32'h000c0000, 32'h000c3fff};
    rwRange[1] = {32'h000d0000, 32'h000d3fff};
    rangeReadEnable = 14'h0001;
    rangeWriteEnable = 14'h0002;
    mainMemorySelectControl = 8'h00; // No ISA memory sits at the aliased areas.
    isaClockDivisor = 8'h00;
    utility_chip_select_enable_a = 8'h00;
    highRangeEnable = 1'b1;
    holeEnable = 1'b1;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      {addr, cmd, cfg, expected} = rows[i];
      setConfig(cfg);
      master.addressPhase(addr, cmd);
      chk({biosPositive, biosSubtractive, encoded_bios_chip_select_n, isaLa20High,
           isaLaTopOnes, main_memory_select_n}, expected);
      @(negedge clk);
      chk(main_memory_select_n, 1'b1);
    end
    // A read from claimed BIOS space is disconnected after its first data phase.
    setConfig(4'h4);
    master.addressPhase(32'h000f0004, 4'hc);
    master.setDone(1'b1);
    #1 chk(targetDisconnect, 1'b1);
    master.setDone(1'b0);
    #1 chk(targetDisconnect, 1'b0);
    master.addressPhase(32'h000f0004, 4'h7);
    master.setDone(1'b1);
    #1 chk(targetDisconnect, 1'b0);
    master.setDone(1'b0);
    // A reset in mid-run drops a held claim; the frame right after release decodes again.
    master.addressPhase(32'h000f0000, 4'h6);
    rst_n = 1'b0;
    @(negedge clk);
    chk({biosPositive, encoded_bios_chip_select_n, main_memory_select_n}, 3'h3);
    rst_n = 1'b1;
    master.addressPhase(32'h000f0000, 4'h6);
    chk({biosPositive, encoded_bios_chip_select_n}, 2'h2);
    // With the hole switched off its addresses are selected by the high range again.
    setConfig(4'h8);
    holeEnable = 1'b0;
    master.addressPhase(32'h00200000, 4'h6);
    chk(main_memory_select_n, 1'b0);
    // With the high range switched off its addresses are no longer selected.
    holeEnable = 1'b1;
    highRangeEnable = 1'b0;
    master.addressPhase(32'h004ffffc, 4'h6);
    chk(main_memory_select_n, 1'b1);
    results();
  end
endmodule : pbd_decoder_test
